// file: rtl/factory_cmd_map.svh
`ifndef FACTORY_CMD_MAP_SVH
`define FACTORY_CMD_MAP_SVH

// Command codes carried on the write data bus
`define CMD_BANK_ERASE_SETUP 16'h0080
`define CMD_ERASE_CONFIRM 16'h00d0
`define CMD_DOUBLE_SETUP 16'h0030
`define CMD_QUAD_SETUP 16'h0055
`define CMD_READ_STATUS 16'h0070
`define CMD_READ_ARRAY 16'h00ff
`define CMD_READ_SIGNATURE 16'h0090
`define CMD_READ_QUERY 16'h0098
`define CMD_CLEAR_STATUS 16'h0050

// Status register field positions
`define SR_READY_BIT 7
`define SR_ERASE_ERR_BIT 5
`define SR_PROG_ERR_BIT 4

// Reset value of the status byte: controller ready, no errors
`define SR_RESET_VALUE 8'h80

// Word counts of the multi-word programs
`define DOUBLE_WORDS 3'd2
`define QUAD_WORDS 3'd4

`endif

// file: rtl/factory_cmd_pkg.sv
package factory_cmd_pkg;

  // Command sequencer states
  typedef enum logic [2:0] {
    SEQ_IDLE = 3'b000,
    SEQ_ERASE_CONFIRM = 3'b001,
    SEQ_LOAD_WORDS = 3'b010,
    SEQ_BUSY = 3'b011
  } seq_state_t;

  // Kind of operation handed to the program/erase controller
  typedef enum logic [1:0] {
    OP_NONE = 2'b00,
    OP_BANK_ERASE = 2'b01,
    OP_PROGRAM2 = 2'b10,
    OP_PROGRAM4 = 2'b11
  } op_kind_t;

  // Read mode of a bank
  typedef enum logic [1:0] {
    RM_ARRAY = 2'b00,
    RM_STATUS = 2'b01,
    RM_SIGNATURE = 2'b10,
    RM_QUERY = 2'b11
  } read_mode_t;

endpackage

// file: rtl/word_latch.sv
`timescale 1ns/1ps
`include "factory_cmd_map.svh"

// Holds up to four data words and the first address of a multi-word program
module word_latch #(
  parameter int ADDR_W = 22,
  parameter int DATA_W = 16
) (
  input wire logic clk,
  input wire logic rst,
  input wire logic clear,
  input wire logic load,
  input wire logic [ADDR_W-1:0] addr_in,
  input wire logic [DATA_W-1:0] data_in,
  output logic [2:0] count,
  output logic [ADDR_W-1:0] first_word_address,
  output logic [4*DATA_W-1:0] words
);

  // --------------------------------------------------------------
  // Storage
  // --------------------------------------------------------------
  logic [DATA_W-1:0] mem_q [4]; // Latched program words
  logic [2:0] count_q; // Number of words latched

  // Count of latched words, cleared at each new setup
  always_ff @(posedge clk)
  begin
    if (rst || clear)
      count_q <= 3'd0;
    else if (load && count_q < `QUAD_WORDS)
      count_q <= count_q + 3'd1;
  end

  // First address marks the start of the page
  always_ff @(posedge clk)
  begin
    if (rst)
      first_word_address <= '0;
    else if (load && count_q == 3'd0)
      first_word_address <= addr_in;
  end

  // Word store, indexed by arrival order
  always_ff @(posedge clk)
  begin
    if (rst)
    begin
      for (int i = 0; i < 4; i++)
        mem_q[i] <= '0;
    end
    else if (load && count_q < `QUAD_WORDS)
      mem_q[count_q[1:0]] <= data_in;
  end

  assign count = count_q;

  // Pack words, first word in the low lane
  always_comb
  begin
    for (int i = 0; i < 4; i++)
      words[i*DATA_W +: DATA_W] = mem_q[i];
  end

endmodule // word_latch

// file: rtl/factory_cmd_seq.sv
// Chosen here: the strobed register port and the register addresses.
`timescale 1ns/1ps
`include "factory_cmd_map.svh"

// Functional notes
// - Bank erase sets unprotected bank bits one
// - Skip protected blocks; all protected aborts quietly
// - Erase is 80h then D0h, starts controller
// - Missing confirm sets both error flags
// - Reset aborts bank erase; host re-erases
// - Erasing bank reads status until read command
// - Erasing bank accepts only read status
// - No other-bank operations while factory busy
// - Double program: 30h, two pairs, then start
// - Programming bank reads return status
// - Double program bank accepts only read status
// - Reset aborts multi-word program; host reprograms
// - Quad program: 55h, four pairs, then start
// - Quad program: only read status, no dual
// - Ready flag low while controller busy
// - Error flags sticky until clear or reset

module factory_cmd_seq
#(
  parameter int ADDR_W = 22,
  parameter int DATA_W = 16,
  parameter int BANK_BIT = 21
) (
  input wire logic clk,
  input wire logic rst,
  input wire logic [ADDR_W-1:0] addr,
  input wire logic [DATA_W-1:0] wdata,
  input wire logic wr_stb,
  input wire logic rd_stb,
  output logic [DATA_W-1:0] rdata,
  input wire logic [DATA_W-1:0] array_rdata,
  input wire logic all_protected,
  output logic ctrl_start,
  output factory_cmd_pkg::op_kind_t ctrl_op,
  output logic ctrl_bank,
  output logic [ADDR_W-1:0] first_word_address,
  output logic [4*DATA_W-1:0] ctrl_words,
  input wire logic ctrl_done,
  input wire logic ctrl_fail,
  output logic controller_ready_flag,
  output logic program_error_flag,
  output logic erase_error_flag
);
  import factory_cmd_pkg::*;

  // --------------------------------------------------------------
  // Elaboration checks
  // --------------------------------------------------------------
  if (BANK_BIT >= ADDR_W || ADDR_W < 3 || DATA_W < 8)
    $error("factory_cmd_seq: unsupported widths");

  // --------------------------------------------------------------
  // Helpers
  // --------------------------------------------------------------
  // Bank that an address falls in
  function automatic logic bank_of(input logic [ADDR_W-1:0] a);
    return a[BANK_BIT];
  endfunction

  // Low byte of a data word compared against a command code
  function automatic logic is_cmd(input logic [DATA_W-1:0] d,
                                  input logic [15:0] code);
    return d[7:0] == code[7:0];
  endfunction

  // --------------------------------------------------------------
  // State
  // --------------------------------------------------------------
  seq_state_t state_q; // Sequencer state
  op_kind_t op_q; // Operation being set up or run
  logic bank_q; // Bank owning the operation
  read_mode_t mode_q [2]; // Read mode per bank
  logic [7:0] status_q; // Shared status byte
  logic latch_clear; // Restart word capture
  logic latch_load; // Capture one address/data pair
  logic [2:0] latch_count; // Words captured so far
  logic [2:0] need_words; // Words the current program needs
  logic erase_go; // Confirm write that launches a bank erase
  logic program_go; // Last pair write that launches a program
  logic start_d; // Controller launch decided this cycle
  logic rdata_sel_status; // Read should return status
  logic [DATA_W-1:0] rdata_d; // Next read data

  // Words the pending program needs before it may start
  assign need_words = (op_q == OP_PROGRAM4) ? `QUAD_WORDS
                                            : `DOUBLE_WORDS;

  // --------------------------------------------------------------
  // Launch decode
  // --------------------------------------------------------------
  // A good confirm on a bank that is not fully protected
  assign erase_go = wr_stb && state_q == SEQ_ERASE_CONFIRM
                    && is_cmd(wdata, `CMD_ERASE_CONFIRM)
                    && !all_protected;
  // The pair that completes the page
  assign program_go = wr_stb && state_q == SEQ_LOAD_WORDS
                      && latch_count == need_words - 3'd1;
  // Ready must fall on the same edge as the start pulse rises, so
  // a poll right after the last write never sees a stale ready
  assign start_d = erase_go || program_go;

  // --------------------------------------------------------------
  // Word capture
  // --------------------------------------------------------------
  // Setup write clears capture; each pair write loads one word
  assign latch_clear = (state_q == SEQ_IDLE) && wr_stb;
  assign latch_load = (state_q == SEQ_LOAD_WORDS) && wr_stb;

  word_latch #(
    .ADDR_W(ADDR_W),
    .DATA_W(DATA_W)
  ) u_words (
    .clk(clk),
    .rst(rst),
    .clear(latch_clear),
    .load(latch_load),
    .addr_in(addr),
    .data_in(wdata),
    .count(latch_count),
    .first_word_address(first_word_address),
    .words(ctrl_words)
  );

  // --------------------------------------------------------------
  // Command sequencer
  // --------------------------------------------------------------
  // Synchronous reset abandons any running operation
  always_ff @(posedge clk)
  begin
    if (rst)
    begin
      state_q <= SEQ_IDLE;
      op_q <= OP_NONE;
      bank_q <= 1'b0;
    end
    else
    begin
      case (state_q)
        SEQ_IDLE:
        begin
          if (wr_stb)
          begin
            bank_q <= bank_of(addr);
            if (is_cmd(wdata, `CMD_BANK_ERASE_SETUP))
            begin
              op_q <= OP_BANK_ERASE;
              state_q <= SEQ_ERASE_CONFIRM;
            end
            else if (is_cmd(wdata, `CMD_DOUBLE_SETUP))
            begin
              op_q <= OP_PROGRAM2;
              state_q <= SEQ_LOAD_WORDS;
            end
            else if (is_cmd(wdata, `CMD_QUAD_SETUP))
            begin
              op_q <= OP_PROGRAM4;
              state_q <= SEQ_LOAD_WORDS;
            end
          end
        end
        SEQ_ERASE_CONFIRM:
        begin
          if (wr_stb)
          begin
            // Confirm latches the bank; anything else abandons
            if (is_cmd(wdata, `CMD_ERASE_CONFIRM))
            begin
              bank_q <= bank_of(addr);
              // A fully protected bank aborts quietly, nothing runs
              state_q <= all_protected ? SEQ_IDLE : SEQ_BUSY;
            end
            else
              state_q <= SEQ_IDLE;
            // Only a launched erase keeps its operation kind
            if (!is_cmd(wdata, `CMD_ERASE_CONFIRM) || all_protected)
              op_q <= OP_NONE;
          end
        end
        SEQ_LOAD_WORDS:
        begin
          // Last pair starts the controller; earlier pairs only latch
          if (program_go)
            state_q <= SEQ_BUSY;
        end
        SEQ_BUSY:
        begin
          // Every write is dropped while busy, in either bank, so no
          // second operation can overlap
          if (ctrl_done)
          begin
            // Done or failed, the sequencer is free again
            state_q <= SEQ_IDLE;
            op_q <= OP_NONE;
          end
        end
        default:
          state_q <= SEQ_IDLE;
      endcase
    end
  end

  // --------------------------------------------------------------
  // Controller start pulse
  // --------------------------------------------------------------
  // One-cycle start in the cycle after the final command write
  always_ff @(posedge clk)
  begin
    if (rst)
    begin
      ctrl_start <= 1'b0;
      ctrl_op <= OP_NONE;
      ctrl_bank <= 1'b0;
    end
    else
    begin
      ctrl_start <= 1'b0;
      if (erase_go)
      begin
        ctrl_start <= 1'b1;
        ctrl_op <= OP_BANK_ERASE;
        ctrl_bank <= bank_of(addr);
      end
      else if (program_go)
      begin
        ctrl_start <= 1'b1;
        ctrl_op <= op_q;
        ctrl_bank <= bank_q;
      end
    end
  end

  // --------------------------------------------------------------
  // Read modes per bank
  // --------------------------------------------------------------
  // Start puts the launched bank in status; read cmds change modes only while the sequencer is idle
  always_ff @(posedge clk)
  begin
    if (rst)
    begin
      mode_q[0] <= RM_ARRAY;
      mode_q[1] <= RM_ARRAY;
    end
    else if (ctrl_start)
      mode_q[ctrl_bank] <= RM_STATUS;
    else if (wr_stb && state_q == SEQ_IDLE)
    begin
      // Read commands only change the mode of the addressed bank
      if (is_cmd(wdata, `CMD_READ_ARRAY))
        mode_q[bank_of(addr)] <= RM_ARRAY;
      else if (is_cmd(wdata, `CMD_READ_SIGNATURE))
        mode_q[bank_of(addr)] <= RM_SIGNATURE;
      else if (is_cmd(wdata, `CMD_READ_QUERY))
        mode_q[bank_of(addr)] <= RM_QUERY;
      else if (is_cmd(wdata, `CMD_READ_STATUS))
        mode_q[bank_of(addr)] <= RM_STATUS;
    end
  end

  // --------------------------------------------------------------
  // Status byte
  // --------------------------------------------------------------
  // Errors are sticky; a set in the same cycle beats a clear
  always_ff @(posedge clk)
  begin
    if (rst)
      status_q <= `SR_RESET_VALUE;
    else
    begin
      // Ready low from the start edge until done
      if (start_d)
        status_q[`SR_READY_BIT] <= 1'b0;
      else if (state_q == SEQ_BUSY && ctrl_done)
        status_q[`SR_READY_BIT] <= 1'b1;
      // A bad confirm marks both error bits at once
      if (wr_stb && state_q == SEQ_ERASE_CONFIRM
          && !is_cmd(wdata, `CMD_ERASE_CONFIRM))
      begin
        status_q[`SR_PROG_ERR_BIT] <= 1'b1;
        status_q[`SR_ERASE_ERR_BIT] <= 1'b1;
      end
      // A failed verify marks the bit of the operation that ran
      else if (state_q == SEQ_BUSY && ctrl_done && ctrl_fail)
      begin
        if (op_q == OP_BANK_ERASE)
          status_q[`SR_ERASE_ERR_BIT] <= 1'b1;
        else
          status_q[`SR_PROG_ERR_BIT] <= 1'b1;
      end
      else if (wr_stb && state_q == SEQ_IDLE
               && is_cmd(wdata, `CMD_CLEAR_STATUS))
      begin
        status_q[`SR_PROG_ERR_BIT] <= 1'b0;
        status_q[`SR_ERASE_ERR_BIT] <= 1'b0;
      end
    end
  end

  // --------------------------------------------------------------
  // Status flags
  // --------------------------------------------------------------
  // Flags are plain taps of the registered status byte
  assign controller_ready_flag = status_q[`SR_READY_BIT];
  assign program_error_flag = status_q[`SR_PROG_ERR_BIT];
  assign erase_error_flag = status_q[`SR_ERASE_ERR_BIT];

  // --------------------------------------------------------------
  // Read data path
  // --------------------------------------------------------------
  // While busy every bank returns status
  assign rdata_sel_status = (state_q == SEQ_BUSY)
                            || mode_q[bank_of(addr)] == RM_STATUS;

  // Status, else array/query/signature data from outside
  always_comb
  begin
    rdata_d = rdata;
    if (rd_stb)
    begin
      if (rdata_sel_status)
        rdata_d = {{(DATA_W-8){1'b0}}, status_q};
      else
        rdata_d = array_rdata;
    end
  end

  // Read data stands in the cycle after the strobe
  always_ff @(posedge clk)
  begin
    if (rst)
      rdata <= '0;
    else
      rdata <= rdata_d;
  end

endmodule // factory_cmd_seq

// file: dv/factory_cmd_assertions.sv
`timescale 1ns/1ps
// ------------------------------------------------
// Port-level checks of the factory command sequencer
// ------------------------------------------------
module factory_cmd_checker #(
  parameter int ADDR_W = 22,
  parameter int DATA_W = 16,
  parameter int BANK_BIT = 21
) (
  input wire logic clk,
  input wire logic rst,
  input wire logic [ADDR_W-1:0] addr,
  input wire logic [DATA_W-1:0] wdata,
  input wire logic wr_stb,
  input wire logic rd_stb,
  input wire logic [DATA_W-1:0] rdata,
  input wire logic all_protected,
  input wire logic ctrl_start,
  input wire factory_cmd_pkg::op_kind_t ctrl_op,
  input wire logic ctrl_bank,
  input wire logic ctrl_done,
  input wire logic controller_ready_flag,
  input wire logic program_error_flag,
  input wire logic erase_error_flag
);
  import factory_cmd_pkg::*;
  default clocking cb @(posedge clk); endclocking
  default disable iff (rst);
  // Setup write taken while the controller is idle
  sequence s_setup(logic [7:0] c);
    controller_ready_flag && wr_stb && wdata[7:0] == c;
  endsequence
  // Confirm write of a bank erase
  sequence s_confirm(logic prot);
    wr_stb && wdata[7:0] == 8'hd0 && all_protected == prot;
  endsequence
  property p_erase;
    s_setup(8'h80) ##1 s_confirm(1'b0) |=> ctrl_start
      && ctrl_op == OP_BANK_ERASE && ctrl_bank == $past(addr[BANK_BIT]);
  endproperty
  a_erase: assert property (p_erase)
    else $error("bank erase did not start");
  property p_prot;
    s_setup(8'h80) ##1 s_confirm(1'b1) |=> !ctrl_start
      && controller_ready_flag && $stable(erase_error_flag);
  endproperty
  a_prot: assert property (p_prot)
    else $error("protected bank erase misbehaved");
  property p_bad;
    s_setup(8'h80) ##1 (wr_stb && wdata[7:0] != 8'hd0)
      |=> !ctrl_start && program_error_flag && erase_error_flag;
  endproperty
  a_bad: assert property (p_bad)
    else $error("bad confirm did not flag errors");
  property p_dbl;
    s_setup(8'h30) ##1 wr_stb [*2] |=> ctrl_start && ctrl_op == OP_PROGRAM2;
  endproperty
  a_dbl: assert property (p_dbl)
    else $error("two-word program did not start");
  property p_quad;
    s_setup(8'h55) ##1 wr_stb [*4] |=> ctrl_start && ctrl_op == OP_PROGRAM4;
  endproperty
  a_quad: assert property (p_quad)
    else $error("four-word program did not start");
  property p_start;
    ctrl_start |-> !controller_ready_flag;
  endproperty
  a_start: assert property (p_start)
    else $error("ready still high at start");
  property p_done;
    ctrl_done && !controller_ready_flag |=> controller_ready_flag;
  endproperty
  a_done: assert property (p_done)
    else $error("ready not raised after done");
  property p_hold;
    !controller_ready_flag && !ctrl_done |=> !ctrl_start
      && !controller_ready_flag;
  endproperty
  a_hold: assert property (p_hold)
    else $error("busy sequencer accepted a command");
  property p_status;
    rd_stb && !controller_ready_flag && !ctrl_done
      |=> rdata[7] == 1'b0 && rdata[4] == program_error_flag;
  endproperty
  a_status: assert property (p_status)
    else $error("busy read did not return status");
  property p_sticky;
    program_error_flag && !(wr_stb && wdata[7:0] == 8'h50)
      |=> program_error_flag;
  endproperty
  a_sticky: assert property (p_sticky)
    else $error("program error flag dropped");
endmodule // factory_cmd_checker

bind factory_cmd_seq factory_cmd_checker #(.ADDR_W(ADDR_W),
  .DATA_W(DATA_W), .BANK_BIT(BANK_BIT)) factory_cmd_checker_inst (
  .clk, .rst, .addr, .wdata, .wr_stb, .rd_stb, .rdata, .all_protected,
  .ctrl_start, .ctrl_op, .ctrl_bank, .ctrl_done, .controller_ready_flag,
  .program_error_flag, .erase_error_flag
);

// file: dv/pe_ctrl_model.sv
`timescale 1ns/1ps
// ------------------------------------------------
// Program/erase controller and array stand-in
// ------------------------------------------------
module pe_ctrl_model (
  input wire logic clk,
  input wire logic rst,
  input wire logic ctrl_start,
  input wire logic [7:0] delay,
  input wire logic fail_cmd,
  input wire logic [21:0] addr,
  output logic [15:0] array_rdata,
  output logic ctrl_done,
  output logic ctrl_fail
);
  logic [7:0] left_q; // Cycles until the job ends
  // Array data follows the address so every read is checkable
  assign array_rdata = addr[15:0] ^ 16'ha5a5;
  // Count down from start; reset drops the job without a done
  always_ff @(posedge clk)
  begin
    if (rst)
      left_q <= 8'h00;
    else if (ctrl_start)
      left_q <= delay;
    else if (left_q != 8'h00)
      left_q <= left_q - 8'h01;
  end
  assign ctrl_done = (left_q == 8'h01);
  assign ctrl_fail = ctrl_done && fail_cmd;
endmodule // pe_ctrl_model

// file: dv/test_factory_cmd_seq.sv
`timescale 1ns/1ps
module test_factory_cmd_seq;
  import factory_cmd_pkg::*;
  localparam logic [21:0] B0 = 22'h000000; // Lower bank
  localparam logic [21:0] B1 = 22'h200000; // Upper bank
  logic clk, rst, wr_stb, rd_stb, all_protected, fail_cmd;
  logic ctrl_start, ctrl_bank, ctrl_done, ctrl_fail;
  logic controller_ready_flag, program_error_flag, erase_error_flag;
  logic [21:0] addr, first_word_address;
  logic [15:0] wdata, rdata, array_rdata, v;
  logic [15:0] rcode [3];
  logic [7:0] delay;
  logic [63:0] ctrl_words;
  op_kind_t ctrl_op;
  int fails = 0;
  int checks_done = 0;
  factory_cmd_seq factory_cmd_seq_inst (
    .clk, .rst, .addr, .wdata, .wr_stb, .rd_stb, .rdata, .array_rdata,
    .all_protected, .ctrl_start, .ctrl_op, .ctrl_bank, .first_word_address,
    .ctrl_words, .ctrl_done, .ctrl_fail, .controller_ready_flag,
    .program_error_flag, .erase_error_flag
  );
  pe_ctrl_model pe_ctrl_model_inst (
    .clk, .rst, .ctrl_start, .delay, .fail_cmd, .addr, .array_rdata,
    .ctrl_done, .ctrl_fail
  );
  initial
  begin
    clk = 1'b0;
    forever #4 clk = ~clk;
  end
  // ------------------------------------------------
  // Bus tasks and comparison
  // ------------------------------------------------
  task automatic results();
    $display("Checks %0d, mismatches %0d", checks_done, fails);
    if (fails == 0 && checks_done > 0)
      $display("DONE - PASS");
    else
      $display("DONE - FAIL");
    $finish;
  endtask
  task automatic chk(input logic [63:0] seen, input logic [63:0] exp);
    checks_done++;
    if (seen !== exp)
    begin
      fails++;
      $display("Error at %0t: saw %h expected %h", $time, seen, exp);
    end
  endtask
  // Write cycle; strobe stays up so writes can run back to back
  task automatic wr(input logic [21:0] a, input logic [15:0] d);
    @(posedge clk);
    addr <= a;
    wdata <= d;
    rd_stb <= 1'b0;
    wr_stb <= 1'b1;
  endtask
  // Let the last request be taken, then look at settled outputs
  task automatic look();
    @(posedge clk);
    wr_stb <= 1'b0;
    rd_stb <= 1'b0;
    @(negedge clk);
  endtask
  task automatic rd(input logic [21:0] a, output logic [15:0] d);
    @(posedge clk);
    addr <= a;
    rd_stb <= 1'b1;
    wr_stb <= 1'b0;
    look();
    d = rdata;
  endtask
  // Poll ready to the end; a running program is never suspended
  task automatic wait_ready();
    for (int n = 0; n < 400 && controller_ready_flag !== 1'b1; n++)
      @(negedge clk);
    chk(controller_ready_flag, 1'b1);
  endtask
  // Hang guard, far beyond the hundred-odd cycles the tests need
  initial
  begin
    repeat (6000) @(posedge clk);
    fails++;
    results();
  end
  // ------------------------------------------------
  // Test sequence
  // ------------------------------------------------
  initial
  begin
    rst = 1'b1;
    {wr_stb, rd_stb, all_protected, fail_cmd} = 4'b0000;
    addr = B0;
    wdata = 16'h0000;
    delay = 8'd20;
    rcode = '{16'h00ff, 16'h0098, 16'h0090};
    repeat (2) @(posedge clk);
    rst <= 1'b0;
    look();
    chk({controller_ready_flag, program_error_flag, erase_error_flag},
        3'b100);
    // Erase, slow then prompt, left by each read command in turn
    for (int i = 0; i < 3; i++)
    begin
      delay <= (i == 0) ? 8'd20 : 8'd1;
      wr(B1, 16'h0080);
      wr(B1, 16'h00d0);
      look();
      chk({ctrl_start, ctrl_op, ctrl_bank}, {1'b1, OP_BANK_ERASE, 1'b1});
      if (i == 0)
      begin
        wr(B1, 16'h00ff);
        wr(B0, 16'h0030);
        rd(B0, v);
        chk(v[7:0], 8'h00);
        rd(B1 + 22'h12, v);
        chk(v[7:0], 8'h00);
      end
      wait_ready();
      rd(B1 + 22'h12, v);
      chk(v[7:0], 8'h80);
      wr(B1, rcode[i]);
      rd(B1 + 22'h12, v);
      chk(v, 16'h0012 ^ 16'ha5a5);
    end
    // Missing confirm, sticky errors, then clear
    wr(B0, 16'h0080);
    wr(B0, 16'h0040);
    look();
    chk({ctrl_start, program_error_flag, erase_error_flag}, 3'b011);
    wr(B0, 16'h0070);
    rd(B0, v);
    chk(v[7:0], 8'hb0);
    wr(B0, 16'h00ff);
    look();
    chk({program_error_flag, erase_error_flag}, 2'b11);
    wr(B0, 16'h0050);
    look();
    chk({program_error_flag, erase_error_flag}, 2'b00);
    // Erase of a fully protected bank does nothing
    wr(B0, 16'h0080);
    all_protected <= 1'b1;
    wr(B0, 16'h00d0);
    look();
    chk({ctrl_start, controller_ready_flag, erase_error_flag}, 3'b010);
    // Two-word program on adjacent words
    wr(B0, 16'h0030);
    all_protected <= 1'b0;
    delay <= 8'd10;
    wr(B0 + 22'h100, 16'h1111);
    wr(B0 + 22'h101, 16'h2222);
    look();
    chk({ctrl_start, ctrl_op, controller_ready_flag}, {1'b1, OP_PROGRAM2, 1'b0});
    chk({first_word_address, ctrl_words[31:0]}, {22'h100, 32'h22221111});
    wr(B0, 16'h00ff);
    rd(B0 + 22'h100, v);
    chk(v[7:0], 8'h00);
    wait_ready();
    rd(B0 + 22'h100, v);
    chk(v, 16'h0080);
    // Four-word program in the upper bank that fails verify
    fail_cmd <= 1'b1;
    wr(B1, 16'h0055);
    for (int k = 0; k < 4; k++)
      wr(B1 + 22'(64 + k), 16'h0c00 + 16'(k));
    look();
    chk({ctrl_start, ctrl_op, ctrl_bank}, {1'b1, OP_PROGRAM4, 1'b1});
    chk(ctrl_words, 64'h0c03_0c02_0c01_0c00);
    wait_ready();
    chk({program_error_flag, erase_error_flag}, 2'b10);
    wr(B1, 16'h0050);
    fail_cmd <= 1'b0;
    // Reset in mid-operation aborts erase and program alike
    for (int i = 0; i < 2; i++)
    begin
      delay <= 8'd200;
      wr(B0, (i == 0) ? 16'h0080 : 16'h0030);
      wr(B0, (i == 0) ? 16'h00d0 : 16'h0a0a);
      if (i == 1)
        wr(B0 + 22'h1, 16'h0b0b);
      look();
      chk(controller_ready_flag, 1'b0);
      @(posedge clk);
      rst <= 1'b1;
      @(posedge clk);
      rst <= 1'b0;
      look();
      chk({ctrl_start, controller_ready_flag}, 2'b01);
    end
    results();
  end
endmodule // test_factory_cmd_seq
